// *** pcr_pkg.sv ***
// package: register map, field positions, reset values and states
package pcr_pkg;

  // register bank size and address window
  localparam int PCR_NUM_REGS = 9;
  localparam logic [7:0] PCR_OFS_MON_FAULT = 8'h4A;
  localparam logic [7:0] PCR_OFS_SHUTDOWN = 8'h4B;
  localparam logic [7:0] PCR_OFS_ZC_CONFIG = 8'h4C;
  localparam logic [7:0] PCR_OFS_ZC_TRIM = 8'h4D;
  localparam logic [7:0] PCR_OFS_MIN_LIMIT = 8'h4E;
  localparam logic [7:0] PCR_OFS_OV_THR = 8'h4F;
  localparam logic [7:0] PCR_OFS_UV_THR = 8'h50;
  localparam logic [7:0] PCR_OFS_WARN_THR = 8'h51;
  localparam logic [7:0] PCR_OFS_CLEAR = 8'h52;

  // bank indices, offset minus the first offset
  localparam logic [3:0] PCR_IDX_MON_FAULT = 4'h0;
  localparam logic [3:0] PCR_IDX_SHUTDOWN =
    4'(PCR_OFS_SHUTDOWN - PCR_OFS_MON_FAULT);
  localparam logic [3:0] PCR_IDX_ZC_CONFIG =
    4'(PCR_OFS_ZC_CONFIG - PCR_OFS_MON_FAULT);
  localparam logic [3:0] PCR_IDX_ZC_TRIM =
    4'(PCR_OFS_ZC_TRIM - PCR_OFS_MON_FAULT);
  localparam logic [3:0] PCR_IDX_MIN_LIMIT =
    4'(PCR_OFS_MIN_LIMIT - PCR_OFS_MON_FAULT);
  localparam logic [3:0] PCR_IDX_OV_THR =
    4'(PCR_OFS_OV_THR - PCR_OFS_MON_FAULT);
  localparam logic [3:0] PCR_IDX_UV_THR =
    4'(PCR_OFS_UV_THR - PCR_OFS_MON_FAULT);
  localparam logic [3:0] PCR_IDX_WARN_THR =
    4'(PCR_OFS_WARN_THR - PCR_OFS_MON_FAULT);
  localparam logic [3:0] PCR_IDX_CLEAR =
    4'(PCR_OFS_CLEAR - PCR_OFS_MON_FAULT);
  localparam logic [3:0] PCR_IDX_NONE = 4'hF;

  // writable bits of each register; the rest are reserved
  localparam logic [7:0] PCR_MASK [0:8] = '{
    8'h01, 8'h03, 8'h07, 8'h3F, 8'h3F, 8'h07, 8'h07, 8'hFF, 8'h01};
  // values after reset
  localparam logic [7:0] PCR_RESET [0:8] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};

  // field positions
  localparam int PCR_BIT_MON_HICCUP = 0;
  localparam int PCR_BIT_SHD_ENABLE = 1;
  localparam int PCR_BIT_SHD_HICCUP = 0;
  localparam int PCR_BIT_ZC_MID = 2;
  localparam int PCR_BIT_ZC_RESET = 1;
  localparam int PCR_BIT_ZC_DISABLE = 0;
  localparam int PCR_TRIM_MSB = 5;
  localparam int PCR_MIN_THR_MSB = 5;
  localparam int PCR_MIN_THR_LSB = 1;
  localparam int PCR_BIT_MIN_ENABLE = 0;
  localparam int PCR_THR3_MSB = 2;
  localparam int PCR_BIT_CLEAR = 0;

  // special threshold codes
  localparam logic [2:0] PCR_OV_CLAMP_CODE = 3'h4;
  localparam logic [2:0] PCR_UV_OFF_CODE = 3'h4;

  // serial bus framing; device address value is arbitrary
  localparam logic [6:0] PCR_DEV_ADDR_DEFAULT = 7'h20;
  localparam logic [3:0] PCR_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] PCR_LAST_BIT = 4'h7;

  // serial slave states
  typedef enum logic [3:0] {
    PCR_ST_IDLE,
    PCR_ST_ADDR,
    PCR_ST_ADDR_ACK,
    PCR_ST_PTR,
    PCR_ST_PTR_ACK,
    PCR_ST_WDATA,
    PCR_ST_WDATA_ACK,
    PCR_ST_RDATA,
    PCR_ST_RACK
  } pcr_state_t;

endpackage

// *** pcr_sync2.sv ***
// two-flop synchroniser for the serial bus pins
`timescale 1ns/1ps
module pcr_sync2
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // asynchronous pins and their synchronised copies
  input wire logic [1:0] pin_async,
  output logic [1:0] pin_sync
);

  logic [1:0] stage1_reg;
  logic [1:0] stage2_reg;

  // one pair of flops per pin; idle bus level is high
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_sync
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          stage1_reg[i] <= 1'b1;
          stage2_reg[i] <= 1'b1;
        end
        else
        begin
          stage1_reg[i] <= pin_async[i];
          stage2_reg[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

  assign pin_sync = stage2_reg;

endmodule // pcr_sync2

// *** pcr_protection_config_registers.sv ***
// protection configuration register bank behind a serial management slave
`timescale 1ns/1ps
module pcr_protection_config_registers #(
  parameter logic [6:0] DEV_ADDR = pcr_pkg::PCR_DEV_ADDR_DEFAULT
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial management pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // thermal monitor and shutdown controls
  output logic stage_thermal_monitor_hiccup,
  output logic thermal_shutdown_enable,
  output logic thermal_shutdown_hiccup,
  output logic [7:0] stage_thermal_monitor_warn_threshold,
  // zero-cross detection controls
  output logic zero_cross_detect_pwm_mid,
  output logic zero_cross_detect_threshold_reset,
  output logic zero_cross_detect_disable,
  output logic [5:0] zero_cross_detect_trim,
  // minimum-output per-phase limit controls
  output logic [4:0] min_output_limit_disable_threshold,
  output logic min_output_limit_disable_enable,
  // voltage protection thresholds
  output logic [2:0] overvoltage_threshold,
  output logic overvoltage_protection_clamped,
  output logic [2:0] undervoltage_threshold,
  output logic undervoltage_protection_off,
  // over-current status clear strobe
  output logic overcurrent_limit_status_clear
);
  import pcr_pkg::*;

  // map a bus pointer onto a bank index, or none
  function automatic logic [3:0] pcr_index(input logic [7:0] ofs);
    logic [7:0] diff;
    diff = ofs - PCR_OFS_MON_FAULT;
    if (ofs < PCR_OFS_MON_FAULT || ofs > PCR_OFS_CLEAR)
      return PCR_IDX_NONE;
    return diff[3:0];
  endfunction

  logic [1:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  pcr_state_t state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic drive_reg, drive_next;
  logic acked_reg, acked_next;

  logic wr_en;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;
  logic [3:0] rd_idx;
  logic [7:0] rd_byte;

  logic [7:0] mem_reg [0:PCR_NUM_REGS-1];
  logic [7:0] mem_next [0:PCR_NUM_REGS-1];
  logic clear_pulse_reg, clear_pulse_next;
  logic clear_bit;

  // bring both pins into the clock domain
  pcr_sync2 u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_async({scl_in, sda_in}),
    .pin_sync(pins_sync)
  );

  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // previous pin levels for edge and condition detection
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // clock edges and start/stop conditions
  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // read path: unmapped offsets read as zero
  assign rd_idx = pcr_index(ptr_reg);
  assign rd_byte = (rd_idx == PCR_IDX_NONE) ? 8'h00 : mem_reg[rd_idx];
  assign wr_idx = pcr_index(ptr_reg);

  // serial slave: address, pointer, write bytes, read bytes
  always_comb
  begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    drive_next = drive_reg;
    acked_next = acked_reg;
    wr_en = 1'b0;
    wr_data = shift_reg;
    if (stop_det)
    begin
      state_next = PCR_ST_IDLE;
      drive_next = 1'b0;
    end
    else if (start_det)
    begin
      state_next = PCR_ST_ADDR;
      bit_cnt_next = 4'h0;
      drive_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        PCR_ST_IDLE:
        begin
          drive_next = 1'b0;
        end
        PCR_ST_ADDR, PCR_ST_PTR, PCR_ST_WDATA:
        begin
          if (scl_rise && bit_cnt_reg != PCR_BITS_PER_BYTE)
          begin
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end
          else if (scl_fall && bit_cnt_reg == PCR_BITS_PER_BYTE)
          begin
            case (state_reg)
              PCR_ST_ADDR:
              begin
                if (shift_reg[7:1] == DEV_ADDR)
                begin
                  rw_next = shift_reg[0];
                  drive_next = 1'b1;
                  state_next = PCR_ST_ADDR_ACK;
                end
                else
                begin
                  state_next = PCR_ST_IDLE;
                end
              end
              PCR_ST_PTR:
              begin
                ptr_next = shift_reg;
                drive_next = 1'b1;
                state_next = PCR_ST_PTR_ACK;
              end
              default:
              begin
                wr_en = 1'b1;
                ptr_next = ptr_reg + 8'h01;
                drive_next = 1'b1;
                state_next = PCR_ST_WDATA_ACK;
              end
            endcase
          end
        end
        PCR_ST_ADDR_ACK, PCR_ST_PTR_ACK, PCR_ST_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_next = 4'h0;
            drive_next = 1'b0;
            if (state_reg == PCR_ST_ADDR_ACK && rw_reg)
            begin
              shift_next = rd_byte;
              ptr_next = ptr_reg + 8'h01;
              drive_next = ~rd_byte[7];
              state_next = PCR_ST_RDATA;
            end
            else if (state_reg == PCR_ST_ADDR_ACK)
            begin
              state_next = PCR_ST_PTR;
            end
            else
            begin
              state_next = PCR_ST_WDATA;
            end
          end
        end
        PCR_ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_reg == PCR_LAST_BIT)
            begin
              drive_next = 1'b0;
              state_next = PCR_ST_RACK;
            end
            else
            begin
              shift_next = {shift_reg[6:0], 1'b0};
              drive_next = ~shift_reg[6];
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        end
        PCR_ST_RACK:
        begin
          if (scl_rise)
          begin
            acked_next = ~sda_s;
          end
          else if (scl_fall)
          begin
            bit_cnt_next = 4'h0;
            if (acked_reg)
            begin
              shift_next = rd_byte;
              ptr_next = ptr_reg + 8'h01;
              drive_next = ~rd_byte[7];
              state_next = PCR_ST_RDATA;
            end
            else
            begin
              state_next = PCR_ST_IDLE;
            end
          end
        end
        default:
        begin
          state_next = PCR_ST_IDLE;
          drive_next = 1'b0;
        end
      endcase
    end
  end

  // serial slave state registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= PCR_ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      drive_reg <= 1'b0;
      acked_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      drive_reg <= drive_next;
      acked_reg <= acked_next;
    end
  end

  // register writes with reserved bits masked, clear edge detection
  always_comb
  begin
    mem_next = mem_reg;
    clear_pulse_next = 1'b0;
    if (wr_en && wr_idx != PCR_IDX_NONE)
    begin
      mem_next[wr_idx] = wr_data & PCR_MASK[wr_idx];
      if (wr_idx == PCR_IDX_CLEAR && wr_data[PCR_BIT_CLEAR] && !clear_bit)
        clear_pulse_next = 1'b1;
    end
  end

  // register bank storage and clear strobe
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int k = 0; k < PCR_NUM_REGS; k++)
        mem_reg[k] <= PCR_RESET[k];
      clear_pulse_reg <= 1'b0;
    end
    else
    begin
      mem_reg <= mem_next;
      clear_pulse_reg <= clear_pulse_next;
    end
  end

  // open-drain data pin: only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_reg;
  assign clear_bit = mem_reg[PCR_IDX_CLEAR][PCR_BIT_CLEAR];
  assign overcurrent_limit_status_clear = clear_pulse_reg;

  // thermal controls
  assign stage_thermal_monitor_hiccup =
    mem_reg[PCR_IDX_MON_FAULT][PCR_BIT_MON_HICCUP];
  assign thermal_shutdown_enable =
    mem_reg[PCR_IDX_SHUTDOWN][PCR_BIT_SHD_ENABLE];
  assign thermal_shutdown_hiccup =
    mem_reg[PCR_IDX_SHUTDOWN][PCR_BIT_SHD_HICCUP];
  assign stage_thermal_monitor_warn_threshold =
    mem_reg[PCR_IDX_WARN_THR];

  // zero-cross controls
  assign zero_cross_detect_pwm_mid =
    mem_reg[PCR_IDX_ZC_CONFIG][PCR_BIT_ZC_MID];
  assign zero_cross_detect_threshold_reset =
    mem_reg[PCR_IDX_ZC_CONFIG][PCR_BIT_ZC_RESET];
  assign zero_cross_detect_disable =
    mem_reg[PCR_IDX_ZC_CONFIG][PCR_BIT_ZC_DISABLE];
  assign zero_cross_detect_trim =
    mem_reg[PCR_IDX_ZC_TRIM][PCR_TRIM_MSB:0];

  // minimum-output limit controls
  assign min_output_limit_disable_threshold =
    mem_reg[PCR_IDX_MIN_LIMIT][PCR_MIN_THR_MSB:PCR_MIN_THR_LSB];
  assign min_output_limit_disable_enable =
    mem_reg[PCR_IDX_MIN_LIMIT][PCR_BIT_MIN_ENABLE];

  // voltage thresholds and their special codes
  assign overvoltage_threshold = mem_reg[PCR_IDX_OV_THR][PCR_THR3_MSB:0];
  assign overvoltage_protection_clamped =
    (overvoltage_threshold == PCR_OV_CLAMP_CODE);
  assign undervoltage_threshold = mem_reg[PCR_IDX_UV_THR][PCR_THR3_MSB:0];
  assign undervoltage_protection_off =
    (undervoltage_threshold == PCR_UV_OFF_CODE);

  // helper: any reserved bit set anywhere in the bank
  logic rsv_any;
  always_comb
  begin
    rsv_any = 1'b0;
    for (int k = 0; k < PCR_NUM_REGS; k++)
      rsv_any = rsv_any | (|(mem_reg[k] & ~PCR_MASK[k]));
  end

  // checks on register behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_mon_fault_write: assert property (
    wr_en && wr_idx == PCR_IDX_MON_FAULT |=>
      stage_thermal_monitor_hiccup == $past(wr_data[0]))
    else $error("thermal monitor reaction bit not updated");
  a_shutdown_write: assert property (
    wr_en && wr_idx == PCR_IDX_SHUTDOWN |=>
      thermal_shutdown_enable == $past(wr_data[1]) &&
      thermal_shutdown_hiccup == $past(wr_data[0]))
    else $error("shutdown controls not updated");
  a_shutdown_reset: assert property (
    $rose(resetn) |-> !thermal_shutdown_enable && !thermal_shutdown_hiccup)
    else $error("shutdown controls not cleared by reset");
  a_zero_cross_write: assert property (
    wr_en && wr_idx == PCR_IDX_ZC_CONFIG |=>
      {zero_cross_detect_pwm_mid, zero_cross_detect_threshold_reset,
       zero_cross_detect_disable} == $past(wr_data[2:0]))
    else $error("zero-cross controls not updated");
  a_trim_write: assert property (
    wr_en && wr_idx == PCR_IDX_ZC_TRIM |=>
      zero_cross_detect_trim == $past(wr_data[5:0]))
    else $error("trim field not updated");
  a_min_limit_write: assert property (
    wr_en && wr_idx == PCR_IDX_MIN_LIMIT |=>
      min_output_limit_disable_threshold == $past(wr_data[5:1]) &&
      min_output_limit_disable_enable == $past(wr_data[0]))
    else $error("minimum-output limit fields not updated");
  a_ov_clamp_code: assert property (
    wr_en && wr_idx == PCR_IDX_OV_THR |=>
      overvoltage_protection_clamped ==
      ($past(wr_data[2:0]) == PCR_OV_CLAMP_CODE))
    else $error("over-voltage clamp code not decoded");
  a_uv_off_code: assert property (
    wr_en && wr_idx == PCR_IDX_UV_THR |=>
      undervoltage_protection_off ==
      ($past(wr_data[2:0]) == PCR_UV_OFF_CODE))
    else $error("under-voltage disable code not decoded");
  a_warn_reset: assert property (
    $rose(resetn) |-> stage_thermal_monitor_warn_threshold == 8'hFF)
    else $error("warning threshold not 0xFF after reset");
  a_clear_edge_only: assert property (
    overcurrent_limit_status_clear == $rose(clear_bit))
    else $error("clear strobe not tied to a 0 to 1 change");
  a_reserved_zero: assert property (
    !rsv_any)
    else $error("reserved bit holds a one");
  a_ack_driven: assert property (
    state_reg == PCR_ST_ADDR_ACK || state_reg == PCR_ST_PTR_ACK |->
      !sda_oe_n)
    else $error("acknowledge not driven");

  // main scenarios
  c_clear_strobe: cover property (overcurrent_limit_status_clear);
  c_read_byte: cover property (state_reg == PCR_ST_RDATA ##1
    state_reg == PCR_ST_RACK);
  c_uv_off: cover property ($rose(undervoltage_protection_off));
  c_warn_write: cover property (wr_en && wr_idx == PCR_IDX_WARN_THR);

endmodule // pcr_protection_config_registers

// *** pcr_host_model.sv ***
// host model: serial management bus master with open-drain pins
`timescale 1ns/1ps
module pcr_host_model #(
  parameter logic [6:0] DEV_ADDR = pcr_pkg::PCR_DEV_ADDR_DEFAULT
)
(
  // clock
  input wire logic clk,
  // resolved data line as seen on the wire
  input wire logic sda_line,
  // host pin levels, 1 = released to the pull-up
  output logic scl_drv,
  output logic sda_drv
);
  localparam int HALF = 6; // clocks per clock half, above the slave minimum

  // both lines released while the bus is idle
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // wait n clocks, then step to the falling edge
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_drv = 1'b1;
    gap(HALF);
    scl_drv = 1'b1;
    gap(HALF);
    sda_drv = 1'b0;
    gap(HALF);
    scl_drv = 1'b0;
    gap(2);
  endtask

  // stop: data rises while the clock is high
  task automatic stop();
    sda_drv = 1'b0;
    gap(HALF);
    scl_drv = 1'b1;
    gap(HALF);
    sda_drv = 1'b1;
    gap(HALF);
  endtask

  // one bit: data set while clock low, sampled at the end of the high
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    gap(HALF);
    scl_drv = 1'b1;
    gap(HALF);
    s = sda_line;
    scl_drv = 1'b0;
    gap(2); // keeps data changes away from the clock fall
  endtask

  // one byte, msb first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                         output logic [7:0] rx, output logic ack_seen);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_seen);
  endtask

  // write one or two bytes from a pointer, the second auto-increments
  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] d,
                           input int n, output logic acked);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_io(ptr, 1'b1, rx, a1);
    byte_io(n == 2 ? d[15:8] : d[7:0], 1'b1, rx, a2);
    a3 = 1'b0;
    if (n == 2)
      byte_io(d[7:0], 1'b1, rx, a3);
    stop();
    acked = !(a0 | a1 | a2 | a3);
  endtask

  // pointer write, repeated start, one byte read closed by a not-ack
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d,
                          output logic acked);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_io(ptr, 1'b1, rx, a1);
    start();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, rx, a2);
    byte_io(8'hFF, 1'b1, d, a3);
    stop();
    acked = !(a0 | a1 | a2);
  endtask
endmodule // pcr_host_model

// *** test_protection_config_registers.sv ***
// testbench: protection configuration register bank over the serial bus
`timescale 1ns/1ps
module test_protection_config_registers;
  import pcr_pkg::*;
  // clock, reset and bus wires
  logic clk, resetn, scl_drv, sda_drv, sda_line, sda_out, sda_oe_n;
  // configuration outputs
  logic mon_hic, shd_en, shd_hic, zc_mid, zc_rst, zc_dis, min_en;
  logic ov_clamp, uv_off, clr;
  logic [7:0] warn;
  logic [5:0] trim;
  logic [4:0] min_thr;
  logic [2:0] ov, uv;
  logic [33:0] outs;
  int error_cnt = 0;
  int n_tests = 0;
  int clr_cnt = 0;
  logic [7:0] wmask [0:8] = '{8'h01, 8'h03, 8'h07, 8'h3F, 8'h3F, 8'h07,
    8'h07, 8'hFF, 8'h01};

  // open-drain wire: low if either party pulls
  assign sda_line = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
  assign outs = {mon_hic, shd_en, shd_hic, zc_mid, zc_rst, zc_dis, trim,
    min_thr, min_en, ov, ov_clamp, uv, uv_off, warn};

  pcr_protection_config_registers #(.DEV_ADDR(PCR_DEV_ADDR_DEFAULT)) dut_u
  (
    .clk(clk), .resetn(resetn), .scl_in(scl_drv), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .stage_thermal_monitor_hiccup(mon_hic),
    .thermal_shutdown_enable(shd_en), .thermal_shutdown_hiccup(shd_hic),
    .stage_thermal_monitor_warn_threshold(warn),
    .zero_cross_detect_pwm_mid(zc_mid),
    .zero_cross_detect_threshold_reset(zc_rst),
    .zero_cross_detect_disable(zc_dis), .zero_cross_detect_trim(trim),
    .min_output_limit_disable_threshold(min_thr),
    .min_output_limit_disable_enable(min_en),
    .overvoltage_threshold(ov), .overvoltage_protection_clamped(ov_clamp),
    .undervoltage_threshold(uv), .undervoltage_protection_off(uv_off),
    .overcurrent_limit_status_clear(clr)
  );

  pcr_host_model #(.DEV_ADDR(PCR_DEV_ADDR_DEFAULT)) host_u
  (
    .clk(clk), .sda_line(sda_line), .scl_drv(scl_drv), .sda_drv(sda_drv)
  );

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // counts clock cycles with the clear strobe high
  always @(posedge clk)
    if (clr === 1'b1)
      clr_cnt++;

  // expected outputs when every register holds v
  function automatic logic [33:0] field_exp(input logic [7:0] v);
    return {v[0], v[1], v[0], v[2], v[1], v[0], v[5:0], v[5:1], v[0],
      v[2:0], v[2:0] == 3'h4, v[2:0], v[2:0] == 3'h4, v};
  endfunction

  // compare and count
  task automatic check(input logic [33:0] seen, input logic [33:0] exp,
                       input string what);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // reset values at the pins and through the bus
  task automatic t_reset();
    logic [7:0] d;
    logic ok;
    check(outs, 34'h0FF, "rst outs");
    check(sda_oe_n, 1'b1, "rst sda");
    @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 9; i++)
    begin
      host_u.read_reg(PCR_OFS_MON_FAULT + 8'(i), d, ok);
      check({ok, d}, {1'b1, (i == 7) ? 8'hFF : 8'h00}, "rst reg");
    end
    $display("done reset");
  endtask

  // write v everywhere, read back masked, check every field
  task automatic t_pattern(input logic [7:0] v);
    logic [7:0] d;
    logic [33:0] e;
    logic ok;
    for (int i = 0; i < 9; i++)
      host_u.write_reg(PCR_OFS_MON_FAULT + 8'(i), {8'h00, v}, 1, ok);
    e = field_exp(v);
    check(outs[33:28], e[33:28], "thermal zc");
    check(outs[27:0], e[27:0], "fields");
    for (int i = 0; i < 9; i++)
    begin
      host_u.read_reg(PCR_OFS_MON_FAULT + 8'(i), d, ok);
      check({ok, d}, {1'b1, v & wmask[i]}, "readback");
    end
    $display("done pattern %h", v);
  endtask

  // every over- and under-voltage code, reserved bits set, one burst
  task automatic t_thresholds();
    logic ok;
    for (int c = 0; c < 8; c++)
    begin
      host_u.write_reg(PCR_OFS_OV_THR, {5'h1F, 3'(c), 5'h1F, 3'(7 - c)},
        2, ok);
      check({ov, ov_clamp}, {3'(c), c == 4}, "ov code");
      check({uv, uv_off}, {3'(7 - c), c == 3}, "uv code");
    end
    $display("done thresholds");
  endtask

  // only a rising clear bit gives one strobe cycle
  task automatic t_clear();
    logic ok;
    int base;
    base = clr_cnt;
    host_u.write_reg(PCR_OFS_CLEAR, 16'h0001, 1, ok);
    check(34'(clr_cnt - base), 34'h1, "clear rise");
    host_u.write_reg(PCR_OFS_CLEAR, 16'h0001, 1, ok);
    check(34'(clr_cnt - base), 34'h1, "clear held");
    host_u.write_reg(PCR_OFS_CLEAR, 16'h0000, 1, ok);
    host_u.write_reg(PCR_OFS_CLEAR, 16'h00FF, 1, ok);
    check(34'(clr_cnt - base), 34'h2, "clear again");
    $display("done clear");
  endtask

  // wrong device address and unmapped pointer
  task automatic t_refuse();
    logic [7:0] d;
    logic ok, a;
    host_u.write_reg(PCR_OFS_WARN_THR, 16'h0040, 1, ok); // low warning
    check(warn, 8'h40, "warn");
    host_u.start();
    host_u.byte_io({~PCR_DEV_ADDR_DEFAULT, 1'b0}, 1'b1, d, a);
    host_u.byte_io(PCR_OFS_WARN_THR, 1'b1, d, ok);
    host_u.byte_io(8'h00, 1'b1, d, ok);
    host_u.stop();
    check({a, warn}, {1'b1, 8'h40}, "foreign addr");
    host_u.write_reg(8'h60, 16'h00FF, 1, ok);
    host_u.read_reg(8'h60, d, ok);
    check({ok, d}, 9'h100, "unmapped");
    $display("done refuse");
  endtask

  // verdict
  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog, about twice the expected run
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  // main sequence
  initial
  begin
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_pattern(8'hFF);
    t_pattern(8'hAA);
    t_pattern(8'h00);
    t_thresholds();
    t_clear();
    t_refuse();
    conclude();
  end
endmodule // test_protection_config_registers
